// >>> eeprom_pkg.sv
// Package: constants, types and helpers of the serial EEPROM protocol block
// What this block does
// - Ignore all instructions until the power-on reset has been released.
// - Reset gives standby, deselected, latch and busy cleared, protection bits kept.
// - Selection needs a falling chip select edge after power-up or deselection.
// - Active while selected; standby when deselected and no write cycle runs.
// - Hold pauses and resumes only while serial clock is low; bit position kept. The code acts on hold at any clock level.
// - While paused, output floats; data input and clock are ignored.
// - Deselecting during a pause abandons the instruction in progress.
// - Writes and status writes need a clock count that is a multiple of eight.
// - Data-modifying instructions need the write enable latch set beforehand.
// - Latch clears on reset, latch-clear, status-write and memory-write completion.
// - Protect bits: none, C000h-FFFFh, 8000h-FFFFh, or 0000h-FFFFh.
// - Write-protect input guards the block-protect bits.
// - Chip select must rise between last-bit edge and next rising edge.
// - Last bit is an opcode or data byte's eighth bit; reads exempt.
// - Opcodes 06h set latch, 04h clear latch, 05h read status.
// - Opcodes 01h status write, 03h array read, 02h array write.
// - Unknown opcode deselects the device until chip select toggles.
// - Identification opcodes 83h/82h read/write the page with select bit 0.
// - With select bit 1, 83h reads lock status and 82h locks the page.
// - Shift most significant bit first; sample on rise, drive after fall.
// - Status lock bit set with write-protect low refuses status writes.
// - Busy flag is 1 during a write cycle, 0 otherwise.
package eeprom_pkg;
  localparam logic [7:0]  SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0]  CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0]  STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0]  STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0]  ARRAY_READ_CMD        = 8'h03;
  localparam logic [7:0]  ARRAY_WRITE_CMD       = 8'h02;
  localparam logic [7:0]  ID_READ_CMD           = 8'h83;
  localparam logic [7:0]  ID_WRITE_CMD          = 8'h82;
  localparam int          ID_PAGE_SELECT_BIT    = 10;
  localparam int          STAT_BUSY_POS         = 0;
  localparam int          STAT_LATCH_POS        = 1;
  localparam int          STAT_BP_LOW_POS       = 2;
  localparam int          STAT_BP_HIGH_POS      = 3;
  localparam int          STAT_LOCK_POS         = 7;
  localparam logic [15:0] QUARTER_BASE          = 16'hC000;
  localparam logic [15:0] HALF_BASE             = 16'h8000;
  localparam logic [2:0]  PIN_SYNC_RESET        = 3'h2;
  localparam int          CORE_CLK_MHZ          = 100;
  localparam int          WRITE_TIME_US         = 1000;
  localparam int          WRITE_CYCLES          = WRITE_TIME_US * CORE_CLK_MHZ;

  typedef enum logic [1:0] {
    ST_STANDBY  = 2'b00,
    ST_SELECTED = 2'b01,
    ST_IGNORE   = 2'b11
  } frame_state_type;

  typedef enum logic [1:0] {
    PEND_NONE   = 2'b00,
    PEND_STATUS = 2'b01,
    PEND_ARRAY  = 2'b11,
    PEND_LOCK   = 2'b10
  } pend_kind_type;

  function automatic logic opcode_valid(input logic [7:0] op, input logic id_en);
    case (op)
      SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD, STATUS_READ_CMD,
      STATUS_WRITE_CMD, ARRAY_READ_CMD, ARRAY_WRITE_CMD: opcode_valid = 1'b1;
      ID_READ_CMD, ID_WRITE_CMD:                         opcode_valid = id_en;
      default:                                           opcode_valid = 1'b0;
    endcase
  endfunction

  function automatic logic range_protected(input logic [1:0] bp, input logic [15:0] addr);
    case (bp)
      2'b01:   range_protected = (addr >= QUARTER_BASE);
      2'b10:   range_protected = (addr >= HALF_BASE);
      2'b11:   range_protected = 1'b1;
      default: range_protected = 1'b0;
    endcase
  endfunction
endpackage

// >>> spi_link_if.sv
// Interface: signals between the serial-clock side and the core side
interface spi_link_if;
  logic       byte_tgl;
  logic [7:0] rx_byte;
  logic       partial;
  logic [7:0] status_byte;
  logic       id_locked;
  modport link (output byte_tgl, rx_byte, partial, input status_byte, id_locked);
  modport core (input byte_tgl, rx_byte, partial, output status_byte, id_locked);
endinterface

// >>> pin_sync.sv
// Three-stage synchroniser; a change counts once stages two and three agree
module pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_type;
  sync_state_type s_reg;
  sync_state_type s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s_reg.s2[i] == s_reg.s3[i]) begin
        s_next.q[i] = s_reg.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.q;
endmodule // pin_sync

// >>> spi_link.sv
// Serial-clock side: bit shifting, opcode and address capture, output shifting
module spi_link #(
  parameter bit ID_PAGE_EN = 1'b1
) (
  input  wire logic        spi_clk,
  input  wire logic        rst_b,
  input  wire logic        cs_b,
  input  wire logic        mosi,
  input  wire logic        hold_b,
  input  wire logic [7:0]  rd_byte,
  output logic             miso,
  output logic             miso_oe,
  output logic      [15:0] rd_addr,
  output logic             rd_id_page,
  spi_link_if.link         lk
);
  import eeprom_pkg::*;

  typedef struct packed {
    logic [2:0]  bits;
    logic [2:0]  bytes;
    logic [7:0]  shift;
    logic [7:0]  op;
    logic [15:0] addr;
    logic [7:0]  rx;
    logic        tgl;
    logic        partial;
    logic        dead;
  } link_state_type;
  link_state_type s_reg;
  link_state_type s_next;
  logic           first_reg;
  logic [7:0]     tx_reg;
  logic           out_on_reg;
  logic [2:0]     bits_c;
  logic [2:0]     bytes_c;
  logic           reading;

  // Frame start marker, preset while deselected
  always_ff @(posedge spi_clk or posedge cs_b or negedge rst_b) begin
    if (!rst_b || cs_b) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  always_comb begin
    s_next  = s_reg;
    bits_c  = first_reg ? 3'h0 : s_reg.bits;
    bytes_c = first_reg ? 3'h0 : s_reg.bytes;
    if (!cs_b && hold_b) begin
      s_next.bits  = bits_c;
      s_next.bytes = bytes_c;
      s_next.dead  = first_reg ? 1'b0 : s_reg.dead;
      if (!s_next.dead) begin
        s_next.shift   = {s_reg.shift[6:0], mosi};
        s_next.bits    = bits_c + 3'h1;
        s_next.partial = (s_next.bits != 3'h0);
        if (bits_c == 3'h7) begin
          s_next.rx  = s_next.shift;
          s_next.tgl = ~s_reg.tgl;
          if (bytes_c != 3'h7) begin
            s_next.bytes = bytes_c + 3'h1;
          end
          case (bytes_c)
            3'h0: begin
              s_next.op   = s_next.shift;
              s_next.dead = !opcode_valid(s_next.shift, ID_PAGE_EN);
            end
            3'h1: s_next.addr[15:8] = s_next.shift;
            3'h2: s_next.addr[7:0]  = s_next.shift;
            default: s_next.addr    = s_reg.addr + 16'h0001;
          endcase
        end
      end
    end
  end

  always_ff @(posedge spi_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reading = !s_reg.dead && ((s_reg.op == STATUS_READ_CMD && s_reg.bytes != 3'h0) ||
                   ((s_reg.op == ARRAY_READ_CMD || (ID_PAGE_EN && s_reg.op == ID_READ_CMD)) &&
                    s_reg.bytes >= 3'h3));

  // Output byte loads at each byte boundary, then shifts after falling edges
  always_ff @(negedge spi_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_reg     <= '0;
      out_on_reg <= 1'b0;
    end else if (!cs_b && hold_b) begin
      out_on_reg <= reading;
      if (reading && s_reg.bits == 3'h0) begin
        if (s_reg.op == STATUS_READ_CMD) begin
          tx_reg <= lk.status_byte;
        end else if (s_reg.op == ID_READ_CMD && s_reg.addr[ID_PAGE_SELECT_BIT]) begin
          tx_reg <= {7'h00, lk.id_locked};
        end else begin
          tx_reg <= rd_byte;
        end
      end else begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  assign miso        = tx_reg[7];
  assign miso_oe     = !cs_b && hold_b && !first_reg && out_on_reg;
  assign rd_addr     = s_reg.addr;
  assign rd_id_page  = (s_reg.op == ID_READ_CMD);
  assign lk.byte_tgl = s_reg.tgl;
  assign lk.rx_byte  = s_reg.rx;
  assign lk.partial  = s_reg.partial;
endmodule // spi_link

// >>> eeprom_ctrl.sv
// Top: protocol and protection control of a serial EEPROM
module eeprom_ctrl #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
  parameter bit ID_PAGE_EN   = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        spi_clk,
  input  wire logic        cs_b,
  input  wire logic        mosi,
  input  wire logic        hold_b,
  input  wire logic        wp_b,
  output logic             miso,
  output logic             miso_oe,
  output logic      [15:0] rd_addr,
  output logic             rd_id_page,
  input  wire logic [7:0]  rd_byte,
  output logic             page_byte_valid,
  output logic      [7:0]  page_byte,
  output logic             write_commit,
  output logic      [15:0] write_addr,
  output logic             write_id_page,
  input  wire logic [3:0]  nv_in,
  output logic      [3:0]  nv_out,
  output logic             nv_update,
  output logic             write_busy_flag,
  output logic             write_enable_latch,
  output logic             standby_mode
);
  import eeprom_pkg::*;

  localparam int TW = $clog2(WRITE_CYCLES + 1);

  typedef struct packed {
    frame_state_type fsm;
    logic            armed;
    logic            cs_q;
    logic            cs_q2;
    logic            tgl_q;
    logic [2:0]      nbytes;
    logic [7:0]      op;
    logic [15:0]     addr;
    logic [7:0]      data0;
    logic            latch;
    logic            busy;
    logic [TW-1:0]   timer;
    logic            lock_bit;
    logic [1:0]      bp;
    logic            id_lock;
    logic [2:0]      pend_val;
    pend_kind_type   pend;
    logic            nv_loaded;
    logic            nv_update;
    logic            page_valid;
    logic [7:0]      page_byte;
    logic            commit;
    logic [15:0]     waddr;
    logic            wid;
    logic            standby;
  } core_state_type;
  core_state_type s_reg;
  core_state_type s_next;

  spi_link_if lk ();
  logic [2:0] pins_s;
  logic [1:0] link_s;
  logic       cs_s;
  logic       hold_s;
  logic       wp_s;
  logic       tgl_s;
  logic       partial_s;
  logic       hardware_protected_state;
  logic       software_protected_state;
  logic       frame_end;
  logic       frame_ok;

  pin_sync #(.WIDTH(3), .RESET_VAL(PIN_SYNC_RESET)) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d        ({wp_b, hold_b, cs_b}),
    .q        (pins_s)
  );

  pin_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_link_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .d        ({lk.partial, lk.byte_tgl}),
    .q        (link_s)
  );

  spi_link #(.ID_PAGE_EN(ID_PAGE_EN)) u_link (
    .spi_clk    (spi_clk),
    .rst_b      (rst_b),
    .cs_b       (cs_b),
    .mosi       (mosi),
    .hold_b     (hold_b),
    .rd_byte    (rd_byte),
    .miso       (miso),
    .miso_oe    (miso_oe),
    .rd_addr    (rd_addr),
    .rd_id_page (rd_id_page),
    .lk         (lk)
  );

  assign cs_s      = pins_s[0];
  assign hold_s    = pins_s[1];
  assign wp_s      = pins_s[2];
  assign tgl_s     = link_s[0];
  assign partial_s = link_s[1];

  assign hardware_protected_state = s_reg.lock_bit && !wp_s;
  assign software_protected_state = !hardware_protected_state;
  // Frame end lags the synchronised select by one stage so the last byte lands first
  assign frame_end = s_reg.cs_q && !s_reg.cs_q2;
  assign frame_ok  = (s_reg.fsm == ST_SELECTED) && hold_s && !partial_s && !s_reg.busy;

  always_comb begin
    s_next            = s_reg;
    s_next.commit     = 1'b0;
    s_next.nv_update  = 1'b0;
    s_next.page_valid = 1'b0;
    s_next.cs_q       = cs_s;
    s_next.cs_q2      = s_reg.cs_q;
    s_next.tgl_q      = tgl_s;

    // Non-volatile bits come from the array cells once after reset
    if (!s_reg.nv_loaded) begin
      s_next.nv_loaded = 1'b1;
      {s_next.lock_bit, s_next.bp, s_next.id_lock} = nv_in;
    end

    if (cs_s) begin
      s_next.armed = 1'b1;
    end

    // Self-timed write cycle
    if (s_reg.busy) begin
      if (s_reg.timer == '0) begin
        s_next.busy  = 1'b0;
        s_next.latch = 1'b0;
        s_next.pend  = PEND_NONE;
        case (s_reg.pend)
          PEND_STATUS: begin
            s_next.nv_update = 1'b1;
            if (software_protected_state) begin
              {s_next.lock_bit, s_next.bp} = s_reg.pend_val;
            end
          end
          PEND_LOCK: begin
            s_next.nv_update = 1'b1;
            s_next.id_lock   = 1'b1;
          end
          default: ;
        endcase
      end else begin
        s_next.timer = s_reg.timer - TW'(1);
      end
    end

    // Falling select edge, only after select was seen high
    if (!cs_s && s_reg.cs_q && s_reg.armed && s_reg.nv_loaded) begin
      s_next.fsm    = ST_SELECTED;
      s_next.nbytes = 3'h0;
    end

    // Completed byte from the serial side
    if (tgl_s != s_reg.tgl_q && s_reg.fsm == ST_SELECTED) begin
      if (s_reg.nbytes != 3'h7) begin
        s_next.nbytes = s_reg.nbytes + 3'h1;
      end
      case (s_reg.nbytes)
        3'h0: begin
          s_next.op = lk.rx_byte;
          if (!opcode_valid(lk.rx_byte, ID_PAGE_EN)) begin
            s_next.fsm = ST_IGNORE;
          end
        end
        3'h1: begin
          s_next.addr[15:8] = lk.rx_byte;
          s_next.data0      = lk.rx_byte;
        end
        3'h2: s_next.addr[7:0] = lk.rx_byte;
        default: begin
          if (s_reg.op == ARRAY_WRITE_CMD || (ID_PAGE_EN && s_reg.op == ID_WRITE_CMD &&
              !s_reg.addr[ID_PAGE_SELECT_BIT])) begin
            s_next.page_valid = 1'b1;
            s_next.page_byte  = lk.rx_byte;
          end
        end
      endcase
    end

    // Execute at deselection
    if (frame_end) begin
      // An opcode refused in this very cycle still blocks execution
      if (frame_ok && s_next.fsm != ST_IGNORE) begin
        case (s_next.op)
          SET_WRITE_LATCH_CMD: begin
            if (s_next.nbytes == 3'h1) begin
              s_next.latch = 1'b1;
            end
          end
          CLEAR_WRITE_LATCH_CMD: begin
            if (s_next.nbytes == 3'h1) begin
              s_next.latch = 1'b0;
            end
          end
          STATUS_WRITE_CMD: begin
            if (s_next.nbytes == 3'h2 && s_reg.latch && software_protected_state) begin
              s_next.busy     = 1'b1;
              s_next.timer    = TW'(WRITE_CYCLES - 1);
              s_next.pend     = PEND_STATUS;
              s_next.pend_val = {s_next.data0[STAT_LOCK_POS], s_next.data0[STAT_BP_HIGH_POS],
                                 s_next.data0[STAT_BP_LOW_POS]};
            end
          end
          ARRAY_WRITE_CMD: begin
            if (s_next.nbytes >= 3'h4 && s_reg.latch &&
                !range_protected(s_reg.bp, s_next.addr)) begin
              s_next.busy   = 1'b1;
              s_next.timer  = TW'(WRITE_CYCLES - 1);
              s_next.pend   = PEND_ARRAY;
              s_next.commit = 1'b1;
              s_next.waddr  = s_next.addr;
              s_next.wid    = 1'b0;
            end
          end
          ID_WRITE_CMD: begin
            if (ID_PAGE_EN && s_next.nbytes >= 3'h4 && s_reg.latch && !s_reg.id_lock) begin
              s_next.busy  = 1'b1;
              s_next.timer = TW'(WRITE_CYCLES - 1);
              if (s_next.addr[ID_PAGE_SELECT_BIT]) begin
                s_next.pend = PEND_LOCK;
              end else begin
                s_next.pend   = PEND_ARRAY;
                s_next.commit = 1'b1;
                s_next.waddr  = s_next.addr;
                s_next.wid    = 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
      s_next.fsm = ST_STANDBY;
    end

    s_next.standby = (s_next.fsm == ST_STANDBY) && !s_next.busy;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg         <= '0;
      s_reg.fsm     <= ST_STANDBY;
      s_reg.pend    <= PEND_NONE;
      s_reg.standby <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    lk.status_byte                   = 8'h00;
    lk.status_byte[STAT_BUSY_POS]    = s_reg.busy;
    lk.status_byte[STAT_LATCH_POS]   = s_reg.latch;
    lk.status_byte[STAT_BP_LOW_POS]  = s_reg.bp[0];
    lk.status_byte[STAT_BP_HIGH_POS] = s_reg.bp[1];
    lk.status_byte[STAT_LOCK_POS]    = s_reg.lock_bit;
  end

  assign lk.id_locked         = s_reg.id_lock;
  assign page_byte_valid      = s_reg.page_valid;
  assign page_byte            = s_reg.page_byte;
  assign write_commit         = s_reg.commit;
  assign write_addr           = s_reg.waddr;
  assign write_id_page        = s_reg.wid;
  assign nv_out               = {s_reg.lock_bit, s_reg.bp, s_reg.id_lock};
  assign nv_update            = s_reg.nv_update;
  assign write_busy_flag      = s_reg.busy;
  assign write_enable_latch   = s_reg.latch;
  assign standby_mode         = s_reg.standby;
endmodule // eeprom_ctrl

// >>> eeprom_ctrl_sva.sv
// Checker: port assertions of the EEPROM protocol control block
module eeprom_ctrl_chk #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        cs_b,
  input wire logic        hold_b,
  input wire logic        wp_b,
  input wire logic        miso_oe,
  input wire logic        write_commit,
  input wire logic [15:0] write_addr,
  input wire logic        write_id_page,
  input wire logic [3:0]  nv_out,
  input wire logic        nv_update,
  input wire logic        write_busy_flag,
  input wire logic        write_enable_latch,
  input wire logic        standby_mode
);
  int busy_cnt;

  // Length of the current write cycle in core cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= write_busy_flag ? busy_cnt + 1 : 0;
    end
  end

  AST_RESET_STATE: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> !write_enable_latch && !write_busy_flag && standby_mode)
    else $error("Bad state after reset");
  AST_COMMIT_BUSY: assert property (@(posedge core_clk) disable iff (!rst_b)
    write_commit |-> ##[0:2] write_busy_flag)
    else $error("Commit without busy");
  AST_BUSY_LENGTH: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(write_busy_flag) |-> busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1)
    else $error("Write cycle length wrong");
  AST_LATCH_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(write_busy_flag) |-> ##[0:1] !write_enable_latch)
    else $error("Latch kept after write");
  AST_COMMIT_LATCH: assert property (@(posedge core_clk) disable iff (!rst_b)
    write_commit |-> write_enable_latch)
    else $error("Commit without latch");
  AST_COMMIT_RANGE: assert property (@(posedge core_clk) disable iff (!rst_b)
    write_commit && !write_id_page |-> !(nv_out[2:1] == 2'b11 || (nv_out[2:1] == 2'b10 && write_addr[15])
    || (nv_out[2:1] == 2'b01 && &write_addr[15:14])))
    else $error("Commit into protected range");
  AST_STANDBY_BUSY: assert property (@(posedge core_clk) disable iff (!rst_b)
    write_busy_flag |-> !standby_mode)
    else $error("Standby while busy");
  AST_STANDBY_IDLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (cs_b && !write_busy_flag) [*8] |-> standby_mode)
    else $error("No standby when idle");
  AST_OE_SELECT: assert property (@(posedge core_clk) disable iff (!rst_b)
    miso_oe |-> !cs_b && hold_b)
    else $error("Output driven while paused or deselected");
  AST_NV_STABLE: assert property (@(posedge core_clk) disable iff (!rst_b)
    $past(rst_b, 2) && !nv_update && !$past(nv_update) |-> $stable(nv_out))
    else $error("Protection bits changed without update");
  AST_HW_PROTECT: assert property (@(posedge core_clk) disable iff (!rst_b)
    !wp_b && nv_out[3] |=> $stable(nv_out[3:1]))
    else $error("Status bits changed while locked");
endmodule // eeprom_ctrl_chk

bind eeprom_ctrl eeprom_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.core_clk, .rst_b, .cs_b, .hold_b, .wp_b,
  .miso_oe, .write_commit, .write_addr, .write_id_page, .nv_out, .nv_update, .write_busy_flag,
  .write_enable_latch, .standby_mode);

// >>> spi_master.sv
// Partner: SPI bus master, mode 0, clock only runs inside frames
module spi_master (
  output logic      spi_clk,
  output logic      cs_b,
  output logic      mosi,
  output logic      hold_b,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_clk = 1'b0;
    cs_b = 1'b0; // Low through power-up on purpose
    mosi = 1'b0;
    hold_b = 1'b1;
  end

  task automatic sel();
    cs_b = 1'b1;
    #100 cs_b = 1'b0;
    #20;
  endtask

  task automatic bits(input logic [39:0] d, input int n, output logic [39:0] q);
    q = '0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #16 spi_clk = 1'b1;
      q = {q[38:0], miso};
      #16 spi_clk = 1'b0;
    end
    mosi = ~mosi;
  endtask

  task automatic pause(input int n);
    #8 hold_b = 1'b0;
    repeat (n) begin
      mosi = ~mosi;
      #16 spi_clk = 1'b1;
      #16 spi_clk = 1'b0;
    end
    hold_b = 1'b1;
    #16;
  endtask

  task automatic desel();
    #8 cs_b = 1'b1;
    #100;
  endtask
endmodule // spi_master

// >>> eeprom_ctrl_tb.sv
// Testbench of the EEPROM protocol control block
module eeprom_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_pkg::*;
  localparam int          WC  = 100;
  localparam logic [39:0] WEN = 40'(SET_WRITE_LATCH_CMD);
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wp_b = 1'b1;
  logic [7:0]  rd_byte = 8'h00;
  logic [3:0]  nv_in = 4'h2;
  logic        spi_clk, cs_b, mosi, hold_b, miso, miso_oe, rd_id_page, page_byte_valid;
  logic        write_commit, write_id_page, nv_update, write_busy_flag, write_enable_latch, standby_mode;
  logic [15:0] rd_addr, write_addr;
  logic [7:0]  page_byte, last_byte;
  logic [3:0]  nv_out;
  logic [39:0] q;
  logic [15:0] corner [4] = '{16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000};
  int          n_fail = 0;
  int          n_checks = 0;
  int          n_commit = 0;

`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

  eeprom_ctrl #(.WRITE_CYCLES(WC)) uut (.core_clk, .rst_b, .spi_clk, .cs_b, .mosi, .hold_b, .wp_b, .miso,
    .miso_oe, .rd_addr, .rd_id_page, .rd_byte, .page_byte_valid, .page_byte, .write_commit, .write_addr,
    .write_id_page, .nv_in, .nv_out, .nv_update, .write_busy_flag, .write_enable_latch, .standby_mode);
  spi_master m (.spi_clk, .cs_b, .mosi, .hold_b, .miso(miso_oe ? miso : 1'b1));

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    rd_byte <= rd_addr[7:0] ^ rd_addr[15:8];
    if (write_commit) n_commit++;
    if (page_byte_valid) last_byte = page_byte;
  end

  function automatic logic prot(input logic [1:0] bp, input logic [15:0] a);
    return bp == 2'b11 || (bp == 2'b10 && a[15]) || (bp == 2'b01 && a[15:14] == 2'b11);
  endfunction

  task automatic stop_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic xfer(input logic [39:0] d, input int n, input bit w);
    m.sel();
    m.bits(d, n, q);
    m.desel();
    repeat (12) @(posedge core_clk);
    for (int i = 0; w && i < 400 && write_busy_flag !== 1'b0; i++) @(posedge core_clk);
    if (w) `CK(write_busy_flag, 1'b0)
  endtask

  initial begin
    #900000;
    n_fail++;
    stop_test();
  end

  initial begin
    logic [15:0] a;
    logic [7:0]  d;
    int          c;
    void'($urandom(93474));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    `CK({write_enable_latch, write_busy_flag, nv_out}, 6'h02)
    m.bits(WEN, 8, q);
    m.desel();
    `CK(write_enable_latch, 1'b0)
    xfer(WEN, 8, 1'b0);
    `CK(write_enable_latch, 1'b1)
    xfer({STATUS_READ_CMD, 8'h00}, 16, 1'b0);
    `CK(q[7:0], 8'h06)
    xfer(40'(CLEAR_WRITE_LATCH_CMD), 8, 1'b0);
    `CK(write_enable_latch, 1'b0)
    a = {1'b0, 15'($urandom)};
    d = 8'($urandom);
    c = n_commit;
    xfer({ARRAY_WRITE_CMD, a, d}, 32, 1'b1);
    `CK(n_commit, c)
    xfer(WEN, 8, 1'b0);
    xfer({ARRAY_WRITE_CMD, a, d, 1'b1}, 33, 1'b1);
    `CK({n_commit - c, write_enable_latch}, {32'd0, 1'b1})
    xfer({ARRAY_WRITE_CMD, a, d}, 32, 1'b0);
    `CK({n_commit - c, write_addr, last_byte, write_busy_flag}, {32'd1, a, d, 1'b1})
    xfer({STATUS_READ_CMD, 8'h00}, 16, 1'b1);
    `CK(q[7:0], 8'h07)
    `CK({write_enable_latch, standby_mode}, 2'b01)
    xfer({ARRAY_READ_CMD, a, 8'h00}, 32, 1'b0);
    `CK({rd_id_page, q[7:0]}, {1'b0, a[7:0] ^ a[15:8]})
    m.sel();
    m.bits(40'h0, 4, q);
    m.pause(5);
    m.bits(40'h6, 4, q);
    m.desel();
    `CK(write_enable_latch, 1'b1)
    m.sel();
    m.bits(40'h4, 8, q);
    #8 m.hold_b = 1'b0;
    #40;
    m.desel();
    m.hold_b = 1'b1;
    `CK(write_enable_latch, 1'b1)
    xfer({8'hFF, 8'h06}, 16, 1'b0);
    `CK(q[7:0], 8'hFF)
    for (int bp = 0; bp < 4; bp++) begin
      xfer(WEN, 8, 1'b0);
      xfer({STATUS_WRITE_CMD, 4'h0, 2'(bp), 2'b00}, 16, 1'b1);
      `CK(nv_out[2:1], 2'(bp))
      for (int j = 0; j < 6; j++) begin
        a = (j < 4) ? corner[j] : 16'($urandom);
        xfer(WEN, 8, 1'b0);
        c = n_commit;
        xfer({ARRAY_WRITE_CMD, a, 8'($urandom)}, 32, 1'b1);
        `CK({n_commit - c, write_enable_latch}, {32'(!prot(2'(bp), a)), prot(2'(bp), a)})
      end
    end
    xfer(WEN, 8, 1'b0);
    xfer({STATUS_WRITE_CMD, 8'h80}, 16, 1'b1);
    wp_b <= 1'b0;
    xfer(WEN, 8, 1'b0);
    xfer({STATUS_WRITE_CMD, 8'h0C}, 16, 1'b1);
    `CK(nv_out[3:1], 3'b100)
    wp_b <= 1'b1;
    xfer({ID_READ_CMD, 16'h0400, 8'h00}, 32, 1'b0);
    `CK({rd_id_page, q[7:0]}, 9'h100)
    xfer(WEN, 8, 1'b0);
    c = n_commit;
    xfer({ID_WRITE_CMD, 16'h0000, 8'h5A}, 32, 1'b1);
    `CK({n_commit - c, write_id_page, last_byte}, {32'd1, 1'b1, 8'h5A})
    xfer(WEN, 8, 1'b0);
    xfer({ID_WRITE_CMD, 16'h0400, 8'h00}, 32, 1'b1);
    xfer({ID_READ_CMD, 16'h0400, 8'h00}, 32, 1'b0);
    `CK({nv_out[0], q[7:0]}, 9'h101)
    xfer(WEN, 8, 1'b0);
    c = n_commit;
    xfer({ID_WRITE_CMD, 16'h0000, 8'h5A}, 32, 1'b1);
    `CK(n_commit, c)
    stop_test();
  end
endmodule // eeprom_ctrl_tb
